// >>> shared/isx_regs.vh
// Constants for the inter-module signal crossbar and comparator input muxes.
// Assumes inclusion by the crossbar and comparator mux modules only.
`ifndef ISX_REGS_VH
`define ISX_REGS_VH

// Crossbar shape
`define ISX_SINKS 30
`define ISX_SOURCES 22
`define ISX_SEL_W 5
`define ISX_SEL_RESET 5'h00

// Source indices
`define ISX_SRC_ZERO 0
`define ISX_SRC_ONE 1
`define ISX_SRC_PIN_LO 2
`define ISX_SRC_PIN_HI 7
`define ISX_SRC_UNUSED 8
`define ISX_SRC_CMP_LO 9
`define ISX_SRC_CMP_HI 11
`define ISX_SRC_TMR_LO 12
`define ISX_SRC_TMR_HI 15
`define ISX_SRC_MOD_LO 16
`define ISX_SRC_MOD_HI 18
`define ISX_SRC_MOD_ALL 19
`define ISX_SRC_MOD3_T0 20
`define ISX_SRC_MOD3_T1 21

// Sink indices
`define ISX_SINK_SYNC_LO 16
`define ISX_SINK_SYNC_HI 19
`define ISX_SINK_TMR_LO 26
`define ISX_SINK_TMR_HI 29

// Comparator input selector codes
`define ISX_CMP_SEL_W 2
`define ISX_CMP_IN0 2'h0
`define ISX_CMP_IN1 2'h1
`define ISX_CMP_IN2 2'h2
`define ISX_CMP_IN3 2'h3
`define ISX_CMP_COUNT 3
`define ISX_VREF_W 5

`endif

// >>> src/isx_cmp_mux.v
// One comparator with its 4-to-1 positive and negative input selectors.
// Assumes analog levels arrive as unsigned words of equal scale.
`include "isx_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module isx_cmp_mux #(
  parameter ANA_W = 12
) (
  // Analog sources
  input wire [`ISX_VREF_W-1:0] vref_code_in,
  input wire [ANA_W-1:0] shared_dac_in,
  input wire [ANA_W-1:0] pin_p2_in,
  input wire [ANA_W-1:0] shared_comparator_reference_pin_in,
  input wire [ANA_W-1:0] pin_m0_in,
  input wire [ANA_W-1:0] pin_m1_in,
  input wire [ANA_W-1:0] pin_m2_in,
  // Pin peripheral mode: bit0 P2, bit1 M0, bit2 M1, bit3 M2
  input wire [3:0] pin_periph_in,
  // Selectors
  input wire [`ISX_CMP_SEL_W-1:0] pos_sel_in,
  input wire [`ISX_CMP_SEL_W-1:0] neg_sel_in,
  // Result
  output wire result_out
);

  wire [ANA_W-1:0] vref_level;
  reg [ANA_W-1:0] pos_level;
  reg [ANA_W-1:0] neg_level;

  // Reference code scaled to full span of the analog word
  assign vref_level = {vref_code_in, {(ANA_W-`ISX_VREF_W){1'b0}}};

  always @* begin
    case (pos_sel_in)
      `ISX_CMP_IN0: pos_level = vref_level;
      `ISX_CMP_IN1: pos_level = shared_dac_in;
      `ISX_CMP_IN2: pos_level = pin_periph_in[0] ? pin_p2_in : {ANA_W{1'b0}};
      `ISX_CMP_IN3: pos_level = shared_comparator_reference_pin_in;
      default: pos_level = {ANA_W{1'b0}};
    endcase
  end

  always @* begin
    case (neg_sel_in)
      `ISX_CMP_IN0: neg_level = pin_periph_in[1] ? pin_m0_in : {ANA_W{1'b0}};
      `ISX_CMP_IN1: neg_level = pin_periph_in[2] ? pin_m1_in : {ANA_W{1'b0}};
      `ISX_CMP_IN2: neg_level = pin_periph_in[3] ? pin_m2_in : {ANA_W{1'b0}};
      `ISX_CMP_IN3: neg_level = shared_dac_in;
      default: neg_level = {ANA_W{1'b0}};
    endcase
  end

  assign result_out = pos_level > neg_level;

endmodule
`default_nettype wire

// >>> src/isx_crossbar.v
// Inter-module signal crossbar with three comparator input muxes.
// Assumes peripherals and pins are synchronous to sys_clk_in; the
// selection path is clocked, the signal path is not.
`include "isx_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module isx_crossbar #(
  parameter SINKS = `ISX_SINKS,
  parameter SOURCES = `ISX_SOURCES,
  parameter ANA_W = 12
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire reset_n_in,
  // Selection write port
  input wire sel_write_in,
  input wire [`ISX_SEL_W-1:0] crossbar_sink_index_in,
  input wire [`ISX_SEL_W-1:0] crossbar_source_index_in,
  input wire system_protection_register_in,
  // Timer routing enables, bits 12 to 15 of the pin select register
  input wire [3:0] system_pin_select_three_in,
  // Digital sources
  input wire [5:0] crossbar_pin_source_in,
  input wire [3:0] timer_b_channel_in,
  input wire [3:0] modulator_trigger_zero_in,
  input wire [3:0] modulator_trigger_one_in,
  // Comparator analog sources, comparator A in the low slice
  input wire [3*`ISX_VREF_W-1:0] vref_code_in,
  input wire [ANA_W-1:0] shared_dac_in,
  input wire [ANA_W-1:0] shared_comparator_reference_pin_in,
  input wire [3*ANA_W-1:0] pin_p2_in,
  input wire [3*ANA_W-1:0] pin_m0_in,
  input wire [3*ANA_W-1:0] pin_m1_in,
  input wire [3*ANA_W-1:0] pin_m2_in,
  input wire [11:0] pin_periph_in,
  input wire [3*`ISX_CMP_SEL_W-1:0] cmp_pos_sel_in,
  input wire [3*`ISX_CMP_SEL_W-1:0] cmp_neg_sel_in,
  // Crossbar sinks
  output wire [SINKS-1:0] crossbar_sink_out,
  output wire [3:0] modulator_sync_out,
  output wire [3:0] timer_b_input_out,
  // Comparator results
  output wire comparator_a_result_out,
  output wire comparator_b_result_out,
  output wire comparator_c_result_out,
  // Selection readback and status
  output reg [`ISX_SEL_W-1:0] sel_readback_out,
  output reg write_refused_out
);

  reg [`ISX_SEL_W-1:0] sel_table [0:SINKS-1];
  wire [SOURCES-1:0] source;
  wire [2:0] cmp_result;
  wire [2:0] modulator0_merged_trigger;
  wire modulators012_merged_trigger;
  wire write_ok;
  wire [`ISX_SEL_W-1:0] sinks_limit;
  wire [`ISX_SEL_W-1:0] sources_limit;
  integer i;

  assign sinks_limit = SINKS[`ISX_SEL_W-1:0];
  assign sources_limit = SOURCES[`ISX_SEL_W-1:0];

  // Comparators
  genvar c;
  generate
    for (c = 0; c < `ISX_CMP_COUNT; c = c + 1) begin : g_cmp
      isx_cmp_mux #(
        .ANA_W(ANA_W)
      ) u_cmp (
        .vref_code_in(vref_code_in[c*`ISX_VREF_W +: `ISX_VREF_W]),
        .shared_dac_in(shared_dac_in),
        .pin_p2_in(pin_p2_in[c*ANA_W +: ANA_W]),
        .shared_comparator_reference_pin_in(shared_comparator_reference_pin_in),
        .pin_m0_in(pin_m0_in[c*ANA_W +: ANA_W]),
        .pin_m1_in(pin_m1_in[c*ANA_W +: ANA_W]),
        .pin_m2_in(pin_m2_in[c*ANA_W +: ANA_W]),
        .pin_periph_in(pin_periph_in[c*4 +: 4]),
        .pos_sel_in(cmp_pos_sel_in[c*`ISX_CMP_SEL_W +: `ISX_CMP_SEL_W]),
        .neg_sel_in(cmp_neg_sel_in[c*`ISX_CMP_SEL_W +: `ISX_CMP_SEL_W]),
        .result_out(cmp_result[c])
      );
    end
  endgenerate

  assign comparator_a_result_out = cmp_result[0];
  assign comparator_b_result_out = cmp_result[1];
  assign comparator_c_result_out = cmp_result[2];

  // Merged modulator triggers, one per submodule 0 to 2
  genvar m;
  generate
    for (m = 0; m < 3; m = m + 1) begin : g_merge
      assign modulator0_merged_trigger[m] = modulator_trigger_zero_in[m] |
                                            modulator_trigger_one_in[m];
    end
  endgenerate
  assign modulators012_merged_trigger = |modulator0_merged_trigger;

  // Shared source vector
  assign source[`ISX_SRC_ZERO] = 1'b0;
  assign source[`ISX_SRC_ONE] = 1'b1;
  assign source[`ISX_SRC_PIN_HI:`ISX_SRC_PIN_LO] = crossbar_pin_source_in;
  assign source[`ISX_SRC_UNUSED] = 1'b0;
  assign source[`ISX_SRC_CMP_HI:`ISX_SRC_CMP_LO] = cmp_result;
  assign source[`ISX_SRC_TMR_HI:`ISX_SRC_TMR_LO] = timer_b_channel_in;
  assign source[`ISX_SRC_MOD_HI:`ISX_SRC_MOD_LO] = modulator0_merged_trigger;
  assign source[`ISX_SRC_MOD_ALL] = modulators12_or_all(modulators012_merged_trigger);
  assign source[`ISX_SRC_MOD3_T0] = modulator_trigger_zero_in[3];
  assign source[`ISX_SRC_MOD3_T1] = modulator_trigger_one_in[3];

  function modulators12_or_all;
    input v;
    begin
      modulators12_or_all = v;
    end
  endfunction

  // Sink muxes; out-of-range codes read as inactive rather than wrap
  genvar s;
  generate
    for (s = 0; s < SINKS; s = s + 1) begin : g_sink
      assign crossbar_sink_out[s] = (sel_table[s] < sources_limit) ?
                                    source[sel_table[s]] : 1'b0;
    end
  endgenerate

  assign modulator_sync_out = crossbar_sink_out[`ISX_SINK_SYNC_HI:`ISX_SINK_SYNC_LO];
  // Gate low holds the timer input idle rather than following the sink
  genvar t;
  generate
    for (t = 0; t < 4; t = t + 1) begin : g_tmr_gate
      assign timer_b_input_out[t] = crossbar_sink_out[`ISX_SINK_TMR_LO + t] &
                                    system_pin_select_three_in[t];
    end
  endgenerate

  // Selection table write; protection blocks the write entirely
  assign write_ok = sel_write_in && !system_protection_register_in &&
                    (crossbar_sink_index_in < sinks_limit);

  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      for (i = 0; i < SINKS; i = i + 1) begin
        sel_table[i] <= `ISX_SEL_RESET;
      end
      write_refused_out <= 1'b0;
    end else begin
      if (write_ok) begin
        sel_table[crossbar_sink_index_in] <= crossbar_source_index_in;
      end
      write_refused_out <= sel_write_in && !write_ok;
    end
  end

  // Readback of the entry named by the sink index
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sel_readback_out <= `ISX_SEL_RESET;
    end else if (crossbar_sink_index_in < sinks_limit) begin
      sel_readback_out <= sel_table[crossbar_sink_index_in];
    end else begin
      sel_readback_out <= `ISX_SEL_RESET;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/isx_crossbar_tb_top.sv
// Bench for the crossbar: routing, protection, gating, comparators.
// Assumes the peripheral model drives the digital sources.
`timescale 1ns/1ps
`default_nettype none
module isx_crossbar_tb_top;
  logic clk = 0, rst_n = 0, wr_s = 0, prot = 0;
  logic [4:0] sink = 0, src = 0;
  logic [3:0] gate = 4'h5;
  logic [17:0] lv = 18'h00000;
  logic [14:0] vref = 15'h7C00;
  logic [11:0] dac = 12'h100, refp = 12'h800;
  logic [5:0] psel = 6'h0D, nsel = 6'h3F;
  logic [35:0] pp2 = 36'h000000000, pm0 = 36'h000000000;
  logic [11:0] per = 12'h000;
  wire logic [5:0] pins;
  wire logic [3:0] tmr, t0, t1, sync, tbi;
  wire logic [29:0] so;
  wire logic [4:0] rb;
  wire logic refused, ca, cb, cc;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  isx_periph_model MDL (.clk_in(clk), .level_in(lv), .pin_out(pins), .tmr_out(tmr),
    .trig0_out(t0), .trig1_out(t1));
  isx_crossbar DUT (.sys_clk_in(clk), .reset_n_in(rst_n), .sel_write_in(wr_s),
    .crossbar_sink_index_in(sink), .crossbar_source_index_in(src),
    .system_protection_register_in(prot), .system_pin_select_three_in(gate),
    .crossbar_pin_source_in(pins), .timer_b_channel_in(tmr), .modulator_trigger_zero_in(t0),
    .modulator_trigger_one_in(t1), .vref_code_in(vref), .shared_dac_in(dac),
    .shared_comparator_reference_pin_in(refp), .pin_p2_in(pp2), .pin_m0_in(pm0),
    .pin_m1_in(36'h0), .pin_m2_in(36'h0), .pin_periph_in(per), .cmp_pos_sel_in(psel),
    .cmp_neg_sel_in(nsel), .crossbar_sink_out(so), .modulator_sync_out(sync),
    .timer_b_input_out(tbi), .comparator_a_result_out(ca), .comparator_b_result_out(cb),
    .comparator_c_result_out(cc), .sel_readback_out(rb), .write_refused_out(refused));
  function automatic logic exp_src(input logic [4:0] s);
    case (s)
      1, 10, 11: return 1'b1;
      2, 3, 4, 5, 6, 7: return lv[s-2];
      12, 13, 14, 15: return lv[s-6];
      16, 17, 18: return lv[s-6] | lv[s-2];
      19: return |(lv[12:10] | lv[16:14]);
      20: return lv[13];
      21: return lv[17];
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [4:0] s);
    @(negedge clk);
    wr_s = 1;
    sink = i;
    src = s;
    @(negedge clk);
    wr_s = 0;
  endtask
  task automatic t_route(input logic [17:0] p);
    lv = p;
    repeat (2) @(negedge clk);
    for (int k = 0; k < 30; k++) begin
      wr(k[4:0], k[4:0] % 22);
      chk(so[k], exp_src(k[4:0] % 22));
      @(negedge clk);
      chk(rb, k % 22);
    end
    chk(sync, {exp_src(5'h13), exp_src(5'h12), exp_src(5'h11), exp_src(5'h10)});
    chk(tbi, {exp_src(5'h07), exp_src(5'h06), exp_src(5'h05), exp_src(5'h04)} & gate);
    chk({cc, cb, ca}, 3'h6);
  endtask
  // Comparator A on pin inputs: P2 against M0, gated by peripheral mode
  task automatic t_cmp();
    psel = 6'h0E;
    nsel = 6'h3C;
    pp2 = 36'h000000300;
    pm0 = 36'h000000200;
    per = 12'h003;
    @(negedge clk);
    chk(ca, 1'b1);
    chk(so[9], 1'b1);
    per = 12'h002;
    @(negedge clk);
    chk(ca, 1'b0);
    per = 12'h001;
    @(negedge clk);
    chk(ca, 1'b1);
    chk(cb, 1'b1);
    per = 12'h000;
    @(negedge clk);
    chk(ca, 1'b0);
    chk(so[9], 1'b0);
  endtask
  task automatic t_protect();
    prot = 1;
    wr(5'h03, 5'h01);
    chk(refused, 1'b1);
    chk(so[3], exp_src(5'h03));
    prot = 0;
    wr(5'h1E, 5'h01);
    chk(refused, 1'b1);
    @(negedge clk);
    chk(refused, 1'b0);
  endtask
  task automatic complete_run();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 200 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    chk(so, 30'h0);
    chk(rb, 5'h00);
    t_route(18'h2A5A5);
    t_route(18'h15A5A);
    t_cmp();
    t_protect();
    complete_run();
  end
endmodule
`default_nettype wire

// >>> testbench/isx_periph_model.sv
// Model of the peripherals feeding the digital crossbar sources.
// Assumes the bench sets levels; outputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module isx_periph_model (
  input wire logic clk_in,
  input wire logic [17:0] level_in,
  output logic [5:0] pin_out,
  output logic [3:0] tmr_out,
  output logic [3:0] trig0_out,
  output logic [3:0] trig1_out
);
  always @(negedge clk_in) begin
    {trig1_out, trig0_out, tmr_out, pin_out} <= level_in;
  end
endmodule
`default_nettype wire

// >>> testbench/isx_xbar_checker.sv
// Assertions on the crossbar top module ports.
// Assumes inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module isx_xbar_checker #(parameter SINKS = 30) (
  // Control inputs
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic sel_write_in,
  input wire logic [4:0] crossbar_sink_index_in,
  input wire logic [4:0] crossbar_source_index_in,
  input wire logic system_protection_register_in,
  input wire logic [3:0] system_pin_select_three_in,
  input wire logic [5:0] crossbar_pin_source_in,
  // Observed outputs
  input wire logic [SINKS-1:0] crossbar_sink_out,
  input wire logic [3:0] modulator_sync_out,
  input wire logic [3:0] timer_b_input_out,
  input wire logic [4:0] sel_readback_out,
  input wire logic write_refused_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic ok_wr;
  wire logic [4:0] src;
  assign src = crossbar_source_index_in;
  assign ok_wr = sel_write_in && !system_protection_register_in && crossbar_sink_index_in < 30;
  a_reset_clears: assert property (disable iff (1'b0)
    !reset_n_in |=> crossbar_sink_out == '0) else $error("sinks not zero after reset");
  a_refused_pulse: assert property (sel_write_in && !ok_wr |=> write_refused_out)
    else $error("ignored write not flagged");
  a_readback_entry: assert property (ok_wr && src < 22 ##1
    (!sel_write_in && $stable(crossbar_sink_index_in)) |=> sel_readback_out == $past(src, 2))
    else $error("readback differs from stored entry");
  a_one_source: assert property (ok_wr && src == 5'h01
    |=> crossbar_sink_out[$past(crossbar_sink_index_in)]) else $error("source one not high");
  a_unused_source: assert property (ok_wr && src == 5'h08
    |=> !crossbar_sink_out[$past(crossbar_sink_index_in)]) else $error("source eight active");
  a_pin_source: assert property (ok_wr && src inside {[2:7]} |=>
    crossbar_sink_out[$past(crossbar_sink_index_in)] == crossbar_pin_source_in[$past(src) - 2])
    else $error("pin source misrouted");
  a_sync_follow: assert property (modulator_sync_out == crossbar_sink_out[19:16])
    else $error("sync outputs differ from sinks");
  a_timer_gate: assert property (timer_b_input_out ==
    (crossbar_sink_out[29:26] & system_pin_select_three_in)) else $error("timer gating wrong");
  c_protected: cover property (sel_write_in && system_protection_register_in);
  c_all_trig: cover property (ok_wr && src == 5'h13);
  c_refused: cover property (write_refused_out);
endmodule
bind isx_crossbar isx_xbar_checker #(.SINKS(SINKS)) u_chk (.sys_clk_in, .reset_n_in,
  .sel_write_in, .crossbar_sink_index_in, .crossbar_source_index_in,
  .system_protection_register_in, .system_pin_select_three_in, .crossbar_pin_source_in,
  .crossbar_sink_out, .modulator_sync_out, .timer_b_input_out, .sel_readback_out,
  .write_refused_out);
`default_nettype wire
